// >>> verilog/xpt_device.sv
// Crosspoint device end: serial slave, command batching, switch state.
// Assumes the controller makes the link clock; both wires are sampled
// through two flops on clk before any logic looks at them.
`timescale 1ns/100ps

// Notes on behaviour
// - All-off code opens every switch; select-high reserved
// - Combined output code drives both outputs
// - Hold commands until a load-marked write
// - Load-marked write applies right after receipt
// - Controller marks only the last batch command
// - Load applies every pending change at once
// - Soft reset bit sits in second byte
// - Soft reset or power-up opens all, outputs low
// - Controller keeps soft reset bit high normally
// - Read starts with address and read direction
// - Device acks a matching read address
// - Exactly two status bytes, only the first then acked
// - Switch status bit one means closed
// - Output status bit shows driven level
// - Top command bit chooses on or off; crosspoint-off codes always turn off
// - Latest pending command per element wins
module xpt_device (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  reset,
    // Serial link
    xpt_link_if.dev                    link,
    // Address straps
    input  wire logic [2:0]            addr_pins,
    // Switch and output state
    output logic [xpt_pkg::NSW-1:0]    switch_state,
    output logic                       general_output_one,
    output logic                       general_output_two
);
    import xpt_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE,
        D_ADDR,
        D_ACK,
        D_WBYTE,
        D_RBYTE,
        D_RACK
    } dst_t;

    typedef struct packed {
        dst_t        st;
        logic [2:0]  bitcnt;
        logic [7:0]  shreg;
        logic        rw;
        logic        ack_on;
        logic        byte_idx;
        logic        rd_idx;
        logic [7:0]  cmd_q;
        logic [15:0] stat_q;
        logic        sda_oe;
        logic [2:0]  pins_s1;
        logic [2:0]  pins_s2;
        elem_t       cur;
        elem_t       pmask;
        elem_t       pval;
    } dev_t;

    dev_t s_q, s_d;
    logic scl_lvl;
    logic scl_rise;
    logic scl_fall;
    logic sda_lvl;
    logic sda_rise;
    logic sda_fall;

    // Serial clock sampling
    pin_sync u_scl (
        .clk   (clk),
        .reset (reset),
        .pin   (link.scl),
        .level (scl_lvl),
        .rise  (scl_rise),
        .fall  (scl_fall)
    );

    // Serial data sampling
    pin_sync u_sda (
        .clk   (clk),
        .reset (reset),
        .pin   (link.sda),
        .level (sda_lvl),
        .rise  (sda_rise),
        .fall  (sda_fall)
    );

    // Link protocol, command batching and element state
    always_comb begin
        cmd_eff_t   eff;
        elem_t      pm;
        elem_t      pv;
        logic [7:0] byte_in;
        eff     = '0;
        pm      = '0;
        pv      = '0;
        byte_in = {s_q.shreg[6:0], sda_lvl};
        s_d     = s_q;

        // Straps pass two flops before the address compare
        s_d.pins_s1 = addr_pins;
        s_d.pins_s2 = s_q.pins_s1;

        if (sda_fall && scl_lvl) begin
            // Start or repeated start
            s_d.st     = D_ADDR;
            s_d.bitcnt = '0;
            s_d.sda_oe = 1'b0;
        end else if (sda_rise && scl_lvl) begin
            // Stop ends any transfer
            s_d.st     = D_IDLE;
            s_d.sda_oe = 1'b0;
        end else if (scl_rise) begin
            case (s_q.st)
                D_ADDR: begin
                    s_d.shreg  = byte_in;
                    s_d.bitcnt = s_q.bitcnt + 3'h1;
                    if (s_q.bitcnt == 3'h7) begin
                        if (byte_in[7:1] == {DEV_ADDR_HI, s_q.pins_s2}) begin
                            s_d.st       = D_ACK;
                            s_d.ack_on   = 1'b0;
                            s_d.rw       = byte_in[0];
                            s_d.byte_idx = 1'b0;
                            s_d.rd_idx   = 1'b0;
                            // Snapshot: switch bits low, outputs above
                            s_d.stat_q   = 16'(s_q.cur);
                        end else begin
                            s_d.st = D_IDLE;
                        end
                    end
                end
                D_WBYTE: begin
                    s_d.shreg  = byte_in;
                    s_d.bitcnt = s_q.bitcnt + 3'h1;
                    if (s_q.bitcnt == 3'h7) begin
                        s_d.st       = D_ACK;
                        s_d.ack_on   = 1'b0;
                        s_d.byte_idx = !s_q.byte_idx;
                        if (!s_q.byte_idx) begin
                            s_d.cmd_q = byte_in;
                        end else if (!byte_in[SRST_POS]) begin
                            // Soft reset clears state and pending batch
                            s_d.cur   = '0;
                            s_d.pmask = '0;
                            s_d.pval  = '0;
                        end else begin
                            eff = decode_cmd(s_q.cmd_q);
                            // Newer command overrides older pending one
                            pm  = s_q.pmask | eff.mask;
                            pv  = (s_q.pval & ~eff.mask) | (eff.val & eff.mask);
                            if (byte_in[LOAD_POS]) begin
                                // All pending changes land in one cycle
                                s_d.cur   = (s_q.cur & ~pm) | (pv & pm);
                                s_d.pmask = '0;
                                s_d.pval  = '0;
                            end else begin
                                s_d.pmask = pm;
                                s_d.pval  = pv;
                            end
                        end
                    end
                end
                D_RBYTE: begin
                    s_d.bitcnt = s_q.bitcnt + 3'h1;
                    if (s_q.bitcnt == 3'h7) begin
                        s_d.st     = D_RACK;
                        s_d.ack_on = 1'b0;
                    end
                end
                D_RACK: begin
                    // Controller ack: low asks for the next byte
                    s_d.ack_on = !sda_lvl;
                end
                default: s_d.st = s_q.st;
            endcase
        end else if (scl_fall) begin
            case (s_q.st)
                D_ACK: begin
                    if (!s_q.ack_on) begin
                        s_d.ack_on = 1'b1;
                        s_d.sda_oe = 1'b1;
                    end else if (s_q.rw) begin
                        // First status byte, msb first
                        s_d.st     = D_RBYTE;
                        s_d.bitcnt = '0;
                        s_d.shreg  = s_q.stat_q[7:0];
                        s_d.sda_oe = !s_q.stat_q[7];
                    end else begin
                        s_d.st     = D_WBYTE;
                        s_d.bitcnt = '0;
                        s_d.sda_oe = 1'b0;
                    end
                end
                D_RBYTE: begin
                    s_d.shreg  = {s_q.shreg[6:0], 1'b0};
                    s_d.sda_oe = !s_q.shreg[6];
                end
                D_RACK: begin
                    s_d.sda_oe = 1'b0;
                    if (s_q.ack_on && !s_q.rd_idx) begin
                        s_d.st     = D_RBYTE;
                        s_d.rd_idx = 1'b1;
                        s_d.bitcnt = '0;
                        s_d.ack_on = 1'b0;
                        s_d.shreg  = s_q.stat_q[15:8];
                        s_d.sda_oe = !s_q.stat_q[15];
                    end else if (s_q.ack_on || s_q.rd_idx) begin
                        // Only two bytes; release the wire afterwards
                        s_d.st = D_IDLE;
                    end
                end
                default: s_d.st = s_q.st;
            endcase
        end
    end

    // Power-up: all switches open, outputs low
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the element state flops
    assign switch_state       = s_q.cur[NSW-1:0];
    assign general_output_one = s_q.cur[GENERAL_OUTPUT_ONE_IDX];
    assign general_output_two = s_q.cur[GENERAL_OUTPUT_TWO_IDX];
    assign link.dev_sda_oe    = s_q.sda_oe;
    assign link.dev_sda_out   = 1'b0;
endmodule

// >>> verilog/xpt_pkg.sv
// Shared constants, command decode and types for the crosspoint link.
// Assumes a 40 MHz system clock on both ends of the serial link.
package xpt_pkg;
    // Link timing: host serial clock made by a quarter-bit divider
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    localparam int QTR_W         = 8;
    localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

    // Device address: upper bits fixed, lower three from straps
    localparam logic [3:0] DEV_ADDR_HI = 4'h9; // Arbitrary value

    // Switchable elements: 12 switches then two general outputs
    localparam int NSW      = 12;
    localparam int NEL      = 14;
    localparam int GENERAL_OUTPUT_ONE_IDX = 12;
    localparam int GENERAL_OUTPUT_TWO_IDX = 13;
    typedef logic [NEL-1:0] elem_t;

    // Command byte layout and codes
    localparam int         SEL_BIT       = 7;
    localparam logic [1:0] CMD_GRP       = 2'h3;
    localparam logic [4:0] CODE_PAIR_LAST = 5'h05;
    localparam logic [4:0] CODE_SW_FIRST = 5'h06;
    localparam logic [4:0] CODE_SW_LAST  = 5'h11;
    localparam logic [4:0] CODE_XP1_OFF  = 5'h12;
    localparam logic [4:0] CODE_XP3_OFF  = 5'h14;
    localparam logic [4:0] CODE_GENERAL_OUTPUT_ONE     = 5'h15;
    localparam logic [4:0] CODE_GENERAL_OUTPUT_TWO     = 5'h16;
    localparam logic [4:0] CODE_GPO_BOTH = 5'h17;
    localparam logic [4:0] CODE_ALL_OFF  = 5'h1F;
    // Per-crosspoint patterns for codes 0..5, code 0 lowest
    localparam logic [23:0] PAIR_PATS = 24'hA5C369;
    localparam logic [3:0]  XP_MASK   = 4'hF;
    localparam elem_t       ALL_SW    = 14'h0FFF;

    // Second data byte layout
    localparam int LOAD_POS = 0;
    localparam int SRST_POS = 1;

    // Host register map and fields
    localparam logic [3:0] REG_CMD    = 4'h0;
    localparam logic [3:0] REG_CTRL   = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_RDATA  = 4'hC;
    localparam int F_CMD_LSB  = 0;
    localparam int F_B2_LSB   = 8;
    localparam int F_ADDR_LSB = 16;
    localparam int CTL_WR_BIT = 0;
    localparam int CTL_RD_BIT = 1;
    localparam logic [1:0] LAST_BYTE = 2'h2;

    typedef struct packed {
        elem_t mask;
        elem_t val;
    } cmd_eff_t;

    // Turns one command byte into the elements it touches and their level
    function automatic cmd_eff_t decode_cmd(input logic [7:0] c);
        cmd_eff_t   e;
        logic [4:0] code;
        logic       on;
        e    = '0;
        code = c[4:0];
        on   = c[SEL_BIT];
        if (c[6:5] == CMD_GRP) begin
            if (code == CODE_ALL_OFF) begin
                e.mask = on ? '0 : ALL_SW;
            end else if (code <= CODE_PAIR_LAST) begin
                e.mask = elem_t'({3{PAIR_PATS[{code[2:0], 2'b00} +: 4]}});
            end else if (code <= CODE_SW_LAST) begin
                e.mask = elem_t'(1) << (code - CODE_SW_FIRST);
            end else if (code <= CODE_XP3_OFF) begin
                e.mask = elem_t'(XP_MASK) << {code - CODE_XP1_OFF, 2'b00};
                on     = 1'b0;
            end else if (code == CODE_GENERAL_OUTPUT_ONE) begin
                e.mask[GENERAL_OUTPUT_ONE_IDX] = 1'b1;
            end else if (code == CODE_GENERAL_OUTPUT_TWO) begin
                e.mask[GENERAL_OUTPUT_TWO_IDX] = 1'b1;
            end else if (code == CODE_GPO_BOTH) begin
                e.mask[GENERAL_OUTPUT_ONE_IDX] = 1'b1;
                e.mask[GENERAL_OUTPUT_TWO_IDX] = 1'b1;
            end
        end
        e.val = on ? e.mask : '0;
        return e;
    endfunction
endpackage

// >>> verilog/xpt_link_if.sv
// Two-wire serial link between the controller and the crosspoint device.
// Assumes pull-ups on both wires; every driver only pulls low.
`timescale 1ns/100ps
interface xpt_link_if;
    logic scl_oe;
    logic scl_out;
    logic host_sda_oe;
    logic host_sda_out;
    logic dev_sda_oe;
    logic dev_sda_out;
    logic scl;
    logic sda;

    // Wired-AND resolution of the open-drain wires
    assign scl = !(scl_oe && !scl_out);
    assign sda = !((host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out));

    modport host (output scl_oe, scl_out, host_sda_oe, host_sda_out, input sda);
    modport dev  (output dev_sda_oe, dev_sda_out, input scl, sda);
endinterface

// >>> verilog/pin_sync.sv
// Two-flop synchroniser with edge pulses for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
module pin_sync #(
    parameter logic RESET_LVL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pin and results
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_t;
    sync_t s_q, s_d;

    // Shift chain; only the second stage reads the first
    always_comb begin
        s_d    = s_q;
        s_d.s1 = pin;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= {3{RESET_LVL}};
        end else begin
            s_q <= s_d;
        end
    end

    // Edges seen between the second and third stages
    assign level = s_q.s2;
    assign rise  = s_q.s2 && !s_q.s3;
    assign fall  = !s_q.s2 && s_q.s3;
endmodule

// >>> verilog/xpt_host.sv
// Controller end: register port in, serial link out, makes the link clock.
// Assumes software polls busy before starting a new transfer.
`timescale 1ns/100ps
module xpt_host (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    // Serial link
    xpt_link_if.host         link
);
    import xpt_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hst_t;
    typedef struct packed {
        hst_t             st;
        logic [QTR_W-1:0] qcnt;
        logic [1:0]       ph;
        logic [3:0]       bitn;
        logic [1:0]       byte_n;
        logic             rw;
        logic             busy;
        logic             nack;
        logic [7:0]       tx;
        logic [7:0]       rx;
        logic [6:0]       dev_addr;
        logic [7:0]       cmd;
        logic [7:0]       b2;
        logic [15:0]      stat;
        logic [31:0]      rd_q;
        logic             scl_oe;
        logic             sda_oe;
    } host_t;
    host_t s_q, s_d;
    logic  sda_lvl;

    pin_sync u_sda (
        .clk   (clk),
        .reset (reset),
        .pin   (link.sda),
        .level (sda_lvl),
        .rise  (),
        .fall  ()
    );

    // Register access, quarter-bit timer and bit sequencer
    always_comb begin
        logic tick;
        logic sending;
        tick    = (s_q.qcnt == QTR_LAST);
        sending = !s_q.rw || (s_q.byte_n == 2'h0);
        s_d      = s_q;
        s_d.rd_q = '0;
        if (wr && addr == REG_CMD) begin
            s_d.cmd      = wdata[F_CMD_LSB +: 8];
            s_d.b2       = wdata[F_B2_LSB +: 8];
            s_d.dev_addr = wdata[F_ADDR_LSB +: 7];
        end else if (wr && addr == REG_CTRL && !s_q.busy
                     && (wdata[CTL_WR_BIT] || wdata[CTL_RD_BIT])) begin
            s_d.st     = H_START;
            s_d.rw     = wdata[CTL_RD_BIT];
            s_d.busy   = 1'b1;
            s_d.nack   = 1'b0;
            s_d.qcnt   = '0;
            s_d.ph     = '0;
            s_d.byte_n = '0;
        end
        if (rd) begin
            case (addr)
                REG_CMD:    s_d.rd_q = {9'h000, s_q.dev_addr, s_q.b2, s_q.cmd};
                REG_STATUS: s_d.rd_q = {30'h00000000, s_q.nack, s_q.busy};
                REG_RDATA:  s_d.rd_q = {16'h0000, s_q.stat};
                default:    s_d.rd_q = '0;
            endcase
        end
        if (s_q.st != H_IDLE) begin
            s_d.qcnt = tick ? '0 : s_q.qcnt + QTR_W'(1);
        end
        if (tick && s_q.st != H_IDLE) begin
            s_d.ph = s_q.ph + 2'h1;
            case (s_q.st)
                H_START: begin
                    if (s_q.ph == 2'h1) s_d.sda_oe = 1'b1;
                    if (s_q.ph == 2'h2) s_d.scl_oe = 1'b1;
                    if (s_q.ph == 2'h3) begin
                        s_d.st   = H_BIT;
                        s_d.bitn = '0;
                        s_d.tx   = {s_q.dev_addr, s_q.rw};
                    end
                end
                H_BIT: begin
                    case (s_q.ph)
                        2'h0: begin
                            if (s_q.bitn == 4'h8) begin
                                // Ack the first status byte, not the last
                                s_d.sda_oe = !sending && s_q.byte_n == 2'h1;
                            end else begin
                                s_d.sda_oe = sending && !s_q.tx[7];
                            end
                        end
                        2'h1: s_d.scl_oe = 1'b0;
                        2'h2: begin
                            if (s_q.bitn != 4'h8) begin
                                s_d.rx = {s_q.rx[6:0], sda_lvl};
                            end else if (sending && sda_lvl) begin
                                s_d.nack = 1'b1;
                            end
                        end
                        default: begin
                            s_d.scl_oe = 1'b1;
                            s_d.tx     = {s_q.tx[6:0], 1'b0};
                            s_d.bitn   = s_q.bitn + 4'h1;
                            if (s_q.bitn == 4'h8) begin
                                s_d.bitn = '0;
                                if (!sending && s_q.byte_n == 2'h1) s_d.stat[7:0] = s_q.rx;
                                if (!sending && s_q.byte_n == LAST_BYTE) s_d.stat[15:8] = s_q.rx;
                                if (s_q.nack || s_q.byte_n == LAST_BYTE) begin
                                    s_d.st = H_STOP;
                                end else begin
                                    s_d.byte_n = s_q.byte_n + 2'h1;
                                    s_d.tx     = (s_q.byte_n == 2'h0) ? s_q.cmd : s_q.b2;
                                end
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    if (s_q.ph == 2'h0) s_d.sda_oe = 1'b1;
                    if (s_q.ph == 2'h1) s_d.scl_oe = 1'b0;
                    if (s_q.ph == 2'h2) s_d.sda_oe = 1'b0;
                    if (s_q.ph == 2'h3) begin
                        s_d.st   = H_IDLE;
                        s_d.busy = 1'b0;
                    end
                end
                default: s_d.st = H_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Pins and read data straight from flops
    assign rdata             = s_q.rd_q;
    assign link.scl_oe       = s_q.scl_oe;
    assign link.scl_out      = 1'b0;
    assign link.host_sda_oe  = s_q.sda_oe;
    assign link.host_sda_out = 1'b0;
endmodule

// >>> testbench/xpt_monitor.sv
// Link checker: timing and drive rules on the two-wire link.
// Assumes it is instantiated beside the interface joining both ends.
`timescale 1ns/100ps
module xpt_monitor (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Link drives and wires
    input  wire logic scl_oe,
    input  wire logic scl_out,
    input  wire logic host_sda_oe,
    input  wire logic host_sda_out,
    input  wire logic dev_sda_oe,
    input  wire logic dev_sda_out,
    input  wire logic scl,
    input  wire logic sda
);
    logic [15:0] lo_q;
    logic [15:0] hi_q;
    logic        sda_q;
    logic        ack_wait_q;
    logic [12:0] ack_cnt_q;
    logic [12:0] hold_cnt_q;

    // Saturating run lengths of the clock wire
    always_ff @(posedge clk) begin
        if (reset) begin
            lo_q <= 16'h0000;
            hi_q <= 16'h0000;
        end else begin
            lo_q <= scl ? 16'h0000 : lo_q + {15'h0000, ~&lo_q};
            hi_q <= !scl ? 16'h0000 : hi_q + {15'h0000, ~&hi_q};
        end
    end

    // Cycles since a start while the address ack is awaited, and length of each device pull
    always_ff @(posedge clk) begin
        if (reset) begin
            sda_q      <= 1'b1;
            ack_wait_q <= 1'b0;
            ack_cnt_q  <= 13'h0000;
            hold_cnt_q <= 13'h0000;
        end else begin
            sda_q      <= sda;
            hold_cnt_q <= dev_sda_oe ? hold_cnt_q + {12'h000, ~&hold_cnt_q} : 13'h0000;
            if (scl && sda_q && !sda) begin
                ack_wait_q <= 1'b1;
                ack_cnt_q  <= 13'h0001;
            end else if (ack_wait_q) begin
                ack_cnt_q <= ack_cnt_q + {12'h000, ~&ack_cnt_q};
                if (dev_sda_oe && ack_cnt_q >= 13'h03E8) begin
                    ack_wait_q <= 1'b0;
                end
            end
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Start condition: data falls while clock high
    sequence start_s;
        scl && $fell(sda);
    endsequence

    a_reset_idle: assert property ($fell(reset) |-> !scl_oe && !host_sda_oe && !dev_sda_oe)
        else $error("link not idle after reset");
    a_addr_ack: assert property (ack_wait_q |-> ack_cnt_q <= 13'h0FA0)
        else $error("no device ack after address");
    a_host_start: assert property (start_s |-> host_sda_oe)
        else $error("start not made by controller");
    a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data moved while clock high");
    a_dev_hold: assert property ($rose(scl) |-> ##1 $stable(dev_sda_oe) [*8])
        else $error("device data not held after clock rise");
    a_scl_low_len: assert property ($rose(scl) |-> lo_q >= 16'h005A)
        else $error("clock low phase too short");
    a_scl_high_len: assert property ($fell(scl) |-> hi_q >= 16'h005A)
        else $error("clock high phase too short");
    a_dev_release: assert property (dev_sda_oe |-> hold_cnt_q < 13'h0FA0)
        else $error("device holds data line too long");
    a_dev_pull_only: assert property (dev_sda_oe |-> !dev_sda_out)
        else $error("device drives data line high");
    a_host_pull_only: assert property ((scl_oe || host_sda_oe) |-> !(scl_out || host_sda_out))
        else $error("controller drives a wire high");
endmodule

// >>> testbench/tb_top.sv
// Bench: controller end and device end joined over the link.
// Assumes straps 3'h5 and the register map of the shared package.
`timescale 1ns/100ps
module tb_top;
    import xpt_pkg::*;
    logic           clk   = 1'b0;
    logic           reset = 1'b1;
    logic           wr    = 1'b0;
    logic           rd    = 1'b0;
    logic [3:0]     addr  = 4'h0;
    logic [31:0]    wdata = 32'h0;
    logic [31:0]    rdata;
    logic [NSW-1:0] sw;
    logic           go1;
    logic           go2;
    int             fail_count  = 0;
    int             check_count = 0;

    // Both ends and the link checker
    xpt_link_if link ();
    xpt_host u_xpt_host (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(link.host));
    xpt_device u_xpt_device (.clk(clk), .reset(reset), .link(link.dev), .addr_pins(3'h5),
        .switch_state(sw), .general_output_one(go1), .general_output_two(go2));
    xpt_monitor u_xpt_monitor (.clk(clk), .reset(reset), .scl_oe(link.scl_oe), .scl_out(link.scl_out),
        .host_sda_oe(link.host_sda_oe), .host_sda_out(link.host_sda_out), .dev_sda_oe(link.dev_sda_oe),
        .dev_sda_out(link.dev_sda_out), .scl(link.scl), .sda(link.sda));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask

    // One register cycle; read data taken in the cycle after
    task automatic bus(input logic [3:0] a, input logic [31:0] d, input logic w, output logic [31:0] q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask

    // One link transfer, polled to completion; returns received bytes
    task automatic xfer(input logic [7:0] c, input logic [7:0] b, input logic r, output logic [31:0] q);
        int n;
        bus(REG_CMD, {9'h000, DEV_ADDR_HI, 3'h5, b, c}, 1'b1, q);
        bus(REG_CTRL, r ? 32'h2 : 32'h1, 1'b1, q);
        q = 32'h1;
        for (n = 0; n < 20000 && q[0] !== 1'b0; n++) begin
            bus(REG_STATUS, 32'h0, 1'b0, q);
        end
        if (q[0] !== 1'b0) begin
            fail_count++;
            end_of_test();
        end
        chk("nack", 32'h0, {31'h0, q[1]});
        bus(REG_RDATA, 32'h0, 1'b0, q);
    endtask

    task automatic st(input string what, input logic [13:0] e);
        chk(what, {18'h0, e}, {18'h0, go2, go1, sw});
    endtask

    // Combined output code applied at once by a load write
    task automatic sc_outputs();
        logic [31:0] q;
        st("reset state", 14'h0000);
        xfer(8'hF7, 8'h03, 1'b0, q);
        st("outputs high", 14'h3000);
    endtask

    // Batch held, then applied; later off beats earlier on
    task automatic sc_batch();
        logic [31:0] q;
        xfer(8'hE6, 8'h02, 1'b0, q);
        xfer(8'hE7, 8'h02, 1'b0, q);
        st("held", 14'h3000);
        xfer(8'h66, 8'h03, 1'b0, q);
        st("batch", 14'h3002);
    endtask

    // Status bytes show switches and output levels
    task automatic sc_read();
        logic [31:0] q;
        xfer(8'h00, 8'h00, 1'b1, q);
        chk("status", 32'h3002, {16'h0, q[15:0]});
    endtask

    // All-off leaves outputs; pair code closes pairs; soft reset clears all
    task automatic sc_clear();
        logic [31:0] q;
        xfer(8'h7F, 8'h03, 1'b0, q);
        st("all off", 14'h3000);
        xfer(8'hE2, 8'h03, 1'b0, q);
        st("pair on", 14'h3333);
        xfer(8'hE7, 8'h01, 1'b0, q);
        st("soft reset", 14'h0000);
    endtask

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        sc_outputs();
        sc_batch();
        sc_read();
        sc_clear();
        end_of_test();
    end
endmodule
